// file: rtl/mdt_edge_detect.sv
`timescale 1ns/1ps
module mdt_edge_detect
  import mdt_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Pin sample and edge outputs
  input  wire logic pinIn,
  output logic      risePulse,
  output logic      fallPulse
);
  typedef struct packed {
    logic prev;
  } mdt_edge_state_t;

  mdt_edge_state_t state_q;
  mdt_edge_state_t state_d;

  always_comb begin
    state_d      = state_q;
    state_d.prev = pinIn;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign risePulse = pinIn & ~state_q.prev;
  assign fallPulse = ~pinIn & state_q.prev;
endmodule : mdt_edge_detect

// file: rtl/mdt_pkg.sv
package mdt_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hAA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hAB;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hAC;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hAD;
  localparam logic [7:0] ADDR_CONTROL     = 8'hAE;
  // Control field positions
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 5;
  localparam int RUN_BIT  = 4;
  localparam int PEND_BIT = 3;
  localparam int IEN_BIT  = 2;
  // Reset values and the underflow compare value
  localparam logic [15:0] COUNT_RESET  = 16'hFFFF;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  // Mode encodings of bits 7..5
  localparam logic [2:0] MODE_EVT_POS = 3'h0;
  localparam logic [2:0] MODE_EVT_NEG = 3'h1;
  localparam logic [2:0] MODE_PWM_TGL = 3'h5;
  localparam logic [2:0] MODE_PWM     = 3'h4;
  localparam logic [2:0] MODE_CAP_POS = 3'h2;
  localparam logic [2:0] MODE_CAP_NEG = 3'h3;

  typedef enum logic [1:0] {MdPwm, MdEvent, MdCapture, MdIdle} mdt_mode_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } mdt_bus_t;
endpackage : mdt_pkg

// file: rtl/mdt_timer.sv
`timescale 1ns/1ps
// Function
// - A 16-bit down counter and one 16-bit reload or capture register exist.
// - Three modes exist: pulse width output, event counting and input capture.
// - Each register is reached as low and high bytes at 0xAA..0xAD, control at 0xAE.
// - One timer pin is used, shared with general port line two.
// - Software starts and stops the timer outside capture mode, where it always runs; a running timer counts down.
// - The counter steps on instruction clocks or on pin edges as the mode selects.
// - Passing 0x0000 to 0xFFFF is underflow and may interrupt, toggle the pin or both.
// - The single interrupt source is underflow or reload register transfer per mode.
// - Reset sets the counter to all ones and the reload register to zero.
// - Control holds mode in 7..5, run or underflow flag in 4, pending 3, enable 2.
// - Pulse width mode counts instruction clocks and reloads at each underflow.
// - Event mode senses the chosen edge; pulses must be at least one cycle wide.
// - An interrupt is requested only with pending, enable and global enable all set.
module mdt_timer
  import mdt_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Instruction clock enable
  input  wire logic             instrTick,
  // Internal data bus
  input  wire mdt_bus_t         bus,
  output logic      [7:0]       rdData,
  output logic                  rdHit,
  // Global interrupt enable from core status
  input  wire logic             globalIrqEnable,
  output logic                  timerIrq,
  // Timer pin, alternate function of port line two
  input  wire logic             timerPinIn,
  input  wire logic             portLineTwoOut,
  output logic                  timerPinOut,
  output logic                  timerPinAltActive
);
  typedef struct packed {
    logic [WIDTH-1:0] downCounter;
    logic [WIDTH-1:0] reloadCaptureReg;
    logic [2:0]       modeSel;
    logic             runOrUnderflowFlag;
    logic             timerIrqPending;
    logic             timerIrqEnable;
    logic             pinToggle;
    logic [7:0]       rdData;
    logic             rdHit;
    logic             irq;
    logic             pinOut;
    logic             altActive;
  } mdt_state_t;

  mdt_state_t state_q;
  mdt_state_t state_d;
  mdt_mode_t  mode;
  logic       pinRise;
  logic       pinFall;
  logic       selEdge;
  logic       stepEn;
  logic       underflow;
  logic       toggleMode;

  mdt_edge_detect u_edge (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .pinIn     (timerPinIn),
    .risePulse (pinRise),
    .fallPulse (pinFall)
  );

  always_comb begin
    unique case (state_q.modeSel)
      MODE_EVT_POS, MODE_EVT_NEG: mode = MdEvent;
      MODE_PWM, MODE_PWM_TGL:     mode = MdPwm;
      MODE_CAP_POS, MODE_CAP_NEG: mode = MdCapture;
      default:                    mode = MdIdle;
    endcase
  end

  assign toggleMode = (state_q.modeSel == MODE_PWM_TGL);
  assign selEdge = state_q.modeSel[0] ? pinFall : pinRise;

  always_comb begin
    stepEn = 1'b0;
    unique case (mode)
      MdPwm:     stepEn = state_q.runOrUnderflowFlag & instrTick;
      MdEvent:   stepEn = state_q.runOrUnderflowFlag & selEdge;
      MdCapture: stepEn = instrTick;
      MdIdle:    stepEn = 1'b0;
    endcase
  end

  assign underflow = stepEn && (state_q.downCounter == COUNT_ZERO[WIDTH-1:0]);

  always_comb begin
    state_d        = state_q;
    state_d.rdHit  = 1'b0;
    state_d.rdData = 8'h00;
    if (stepEn) begin
      state_d.downCounter = state_q.downCounter - 1'b1;
    end
    if (underflow) begin
      if (mode == MdCapture) begin
        state_d.runOrUnderflowFlag = 1'b1;
      end else begin
        state_d.downCounter     = state_q.reloadCaptureReg;
        state_d.timerIrqPending = 1'b1;
        if (toggleMode) begin
          state_d.pinToggle = ~state_q.pinToggle;
        end
      end
    end
    if (bus.wrEn) begin
      unique case (bus.addr)
        ADDR_RELOAD_LOW:  state_d.reloadCaptureReg[7:0]  = bus.wrData;
        ADDR_RELOAD_HIGH: state_d.reloadCaptureReg[15:8] = bus.wrData;
        ADDR_COUNT_LOW:   state_d.downCounter[7:0]       = bus.wrData;
        ADDR_COUNT_HIGH:  state_d.downCounter[15:8]      = bus.wrData;
        ADDR_CONTROL: begin
          state_d.modeSel            = bus.wrData[MODE_MSB:MODE_LSB];
          state_d.runOrUnderflowFlag = bus.wrData[RUN_BIT] |
                                       (underflow && mode == MdCapture);
          state_d.timerIrqPending    = bus.wrData[PEND_BIT] |
                                       state_d.timerIrqPending & ~state_q.timerIrqPending;
          state_d.timerIrqEnable     = bus.wrData[IEN_BIT];
        end
        default: ;
      endcase
    end
    if (mode == MdCapture && selEdge) begin
      state_d.reloadCaptureReg = state_q.downCounter;
      state_d.timerIrqPending  = 1'b1;
    end
    if (bus.rdEn) begin
      state_d.rdHit = 1'b1;
      unique case (bus.addr)
        ADDR_RELOAD_LOW:  state_d.rdData = state_q.reloadCaptureReg[7:0];
        ADDR_RELOAD_HIGH: state_d.rdData = state_q.reloadCaptureReg[15:8];
        ADDR_COUNT_LOW:   state_d.rdData = state_q.downCounter[7:0];
        ADDR_COUNT_HIGH:  state_d.rdData = state_q.downCounter[15:8];
        ADDR_CONTROL:     state_d.rdData = {state_q.modeSel, state_q.runOrUnderflowFlag,
                                            state_q.timerIrqPending, state_q.timerIrqEnable,
                                            2'b00};
        default:          state_d.rdHit  = 1'b0;
      endcase
    end
    state_d.irq = state_d.timerIrqPending & state_d.timerIrqEnable & globalIrqEnable;
    // pin shared with port line two
    state_d.altActive = toggleMode;
    state_d.pinOut    = toggleMode ? (portLineTwoOut ^ state_d.pinToggle) : portLineTwoOut;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q                  <= '0;
      state_q.downCounter      <= COUNT_RESET;
      state_q.reloadCaptureReg <= RELOAD_RESET;
      state_q.modeSel          <= CTRL_RESET[MODE_MSB:MODE_LSB];
    end else begin
      state_q <= state_d;
    end
  end

  assign rdData            = state_q.rdData;
  assign rdHit             = state_q.rdHit;
  assign timerIrq          = state_q.irq;
  assign timerPinOut       = state_q.pinOut;
  assign timerPinAltActive = state_q.altActive;

  // Steps of underflow and interrupt behaviour
  sequence seq_pwm_wrap;
    underflow && mode == MdPwm && !bus.wrEn;
  endsequence

  sequence seq_reloaded;
    state_q.downCounter == $past(state_q.reloadCaptureReg);
  endsequence

  sequence seq_toggle_wrap;
    underflow && toggleMode;
  endsequence

  sequence seq_irq_armed;
    state_q.timerIrqPending && state_q.timerIrqEnable && globalIrqEnable && !bus.wrEn;
  endsequence

  chk_pwm_reload: assert property (@(posedge sys_clk) disable iff (rst)
    seq_pwm_wrap |=> seq_reloaded)
    else $error("reload missing after underflow");

  chk_count_down: assert property (@(posedge sys_clk) disable iff (rst)
    stepEn && !underflow && !bus.wrEn && !(mode == MdCapture && selEdge)
    |=> state_q.downCounter == $past(state_q.downCounter) - 16'h0001)
    else $error("counter did not decrement");

  chk_stopped_hold: assert property (@(posedge sys_clk) disable iff (rst)
    mode == MdPwm && !state_q.runOrUnderflowFlag && !bus.wrEn |=> $stable(state_q.downCounter))
    else $error("stopped counter moved");

  chk_event_idle: assert property (@(posedge sys_clk) disable iff (rst)
    mode == MdEvent && !selEdge && !bus.wrEn |=> $stable(state_q.downCounter))
    else $error("event counter moved without edge");

  chk_idle_hold: assert property (@(posedge sys_clk) disable iff (rst)
    mode == MdIdle && !bus.wrEn |=> $stable(state_q.downCounter))
    else $error("counter moved in unused mode");

  chk_pend_set: assert property (@(posedge sys_clk) disable iff (rst)
    underflow && mode != MdCapture |=> state_q.timerIrqPending)
    else $error("pending not set on underflow");

  chk_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
    timerIrq |-> $past(globalIrqEnable) && state_q.timerIrqEnable && state_q.timerIrqPending)
    else $error("interrupt without all enables");

  chk_irq_follow: assert property (@(posedge sys_clk) disable iff (rst)
    seq_irq_armed |=> timerIrq)
    else $error("interrupt not raised when armed");

  chk_pend_clear: assert property (@(posedge sys_clk) disable iff (rst)
    bus.wrEn && bus.addr == ADDR_CONTROL && !bus.wrData[PEND_BIT] && !underflow
    && !(mode == MdCapture && selEdge) |=> !state_q.timerIrqPending)
    else $error("pending not cleared by write");

  chk_capture_copy: assert property (@(posedge sys_clk) disable iff (rst)
    mode == MdCapture && selEdge |=> state_q.reloadCaptureReg == $past(state_q.downCounter))
    else $error("capture value wrong");

  chk_cap_wrap: assert property (@(posedge sys_clk) disable iff (rst)
    underflow && mode == MdCapture && !bus.wrEn
    |=> state_q.runOrUnderflowFlag && state_q.downCounter == COUNT_RESET)
    else $error("capture underflow not flagged");

  chk_toggle_pin: assert property (@(posedge sys_clk) disable iff (rst)
    seq_toggle_wrap |=> state_q.pinToggle != $past(state_q.pinToggle))
    else $error("pin did not toggle");

  chk_pin_xor: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) && timerPinAltActive
    |-> timerPinOut == ($past(portLineTwoOut) ^ state_q.pinToggle))
    else $error("toggled pin level wrong");

  chk_alt_pin: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> timerPinAltActive == ($past(state_q.modeSel) == MODE_PWM_TGL))
    else $error("alternate function flag wrong");

  chk_pin_plain: assert property (@(posedge sys_clk) disable iff (rst)
    !$past(rst) && !timerPinAltActive |-> timerPinOut == $past(portLineTwoOut))
    else $error("pin did not follow port line");

  chk_read_hit: assert property (@(posedge sys_clk) disable iff (rst)
    bus.rdEn && bus.addr >= ADDR_RELOAD_LOW && bus.addr <= ADDR_CONTROL |=> rdHit)
    else $error("mapped read gave no hit");

  chk_read_miss: assert property (@(posedge sys_clk) disable iff (rst)
    bus.rdEn && (bus.addr < ADDR_RELOAD_LOW || bus.addr > ADDR_CONTROL)
    |=> !rdHit && rdData == 8'h00)
    else $error("unmapped read answered");

  chk_hit_stands: assert property (@(posedge sys_clk) disable iff (rst)
    rdHit |-> $past(bus.rdEn))
    else $error("read hit without read");

  chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (rst)
    bus.rdEn && bus.addr == ADDR_CONTROL |=> rdData[1:0] == 2'h0)
    else $error("reserved control bits not zero");

  chk_ctrl_write: assert property (@(posedge sys_clk) disable iff (rst)
    bus.wrEn && bus.addr == ADDR_CONTROL
    |=> state_q.modeSel == $past(bus.wrData[MODE_MSB:MODE_LSB])
        && state_q.timerIrqEnable == $past(bus.wrData[IEN_BIT]))
    else $error("control write not stored");

  chk_byte_write: assert property (@(posedge sys_clk) disable iff (rst)
    bus.wrEn && bus.addr == ADDR_RELOAD_LOW && !(mode == MdCapture && selEdge)
    |=> state_q.reloadCaptureReg == {$past(state_q.reloadCaptureReg[15:8]), $past(bus.wrData)})
    else $error("byte write disturbed other byte");

  chk_high_write: assert property (@(posedge sys_clk) disable iff (rst)
    bus.wrEn && bus.addr == ADDR_COUNT_HIGH && !stepEn
    |=> state_q.downCounter == {$past(bus.wrData), $past(state_q.downCounter[7:0])})
    else $error("high byte write disturbed low byte");

  chk_reset_vals: assert property (@(posedge sys_clk)
    $past(rst) |-> state_q.downCounter == COUNT_RESET && state_q.reloadCaptureReg == RELOAD_RESET)
    else $error("reset values wrong");
endmodule : mdt_timer

// file: testbench/mdt_cpu_model.sv
`timescale 1ns/1ps
module mdt_cpu_model
  import mdt_pkg::*;
(
  // Clock
  input  wire logic       sys_clk,
  // Core bus side
  output mdt_bus_t        bus,
  input  wire logic [7:0] rdData,
  input  wire logic       rdHit,
  // Core timing and status
  output logic            instrTick,
  output logic            globalIrqEnable
);
  initial begin
    bus = '0;
    instrTick = 1'b0;
    globalIrqEnable = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge sys_clk);
    bus <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge sys_clk);
    bus <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    d = rdData;
    h = rdHit;
  endtask : rd
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      instrTick <= 1'b1;
      @(posedge sys_clk);
      instrTick <= 1'b0;
    end
  endtask : tick
  task automatic gie(input logic en);
    @(posedge sys_clk);
    globalIrqEnable <= en;
  endtask : gie
endmodule : mdt_cpu_model

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import mdt_pkg::*;
  logic       sys_clk, rst, timerPinIn, portLineTwoOut, instrTick, globalIrqEnable;
  logic       rdHit, timerIrq, timerPinOut, timerPinAltActive;
  logic [7:0] rdData;
  mdt_bus_t   bus;
  int         errTotal, compares;

  mdt_timer u_mdt_timer (.sys_clk(sys_clk), .rst(rst), .instrTick(instrTick), .bus(bus),
    .rdData(rdData), .rdHit(rdHit), .globalIrqEnable(globalIrqEnable), .timerIrq(timerIrq),
    .timerPinIn(timerPinIn), .portLineTwoOut(portLineTwoOut), .timerPinOut(timerPinOut),
    .timerPinAltActive(timerPinAltActive));
  mdt_cpu_model u_mdt_cpu_model (.sys_clk(sys_clk), .bus(bus), .rdData(rdData),
    .rdHit(rdHit), .instrTick(instrTick), .globalIrqEnable(globalIrqEnable));

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic h = 1'b1);
    logic [7:0] d;
    logic       g;
    u_mdt_cpu_model.rd(a, d, g);
    chk($sformatf("hit %h", a), {15'h0, h}, {15'h0, g});
    chk($sformatf("byte %h", a), {8'h00, e}, {8'h00, d});
  endtask : rdc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_mdt_cpu_model.wr(a, d);
  endtask : wr
  task automatic waitOut();
    @(posedge sys_clk);
    #1;
  endtask : waitOut
  // One rising and one falling pin edge, two cycles wide
  task automatic pulse();
    @(posedge sys_clk);
    timerPinIn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    timerPinIn <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : pulse

  task automatic test_reset();
    rdc(ADDR_RELOAD_LOW, 8'h00);
    rdc(ADDR_RELOAD_HIGH, 8'h00);
    rdc(ADDR_COUNT_LOW, 8'hFF);
    rdc(ADDR_COUNT_HIGH, 8'hFF);
    rdc(ADDR_CONTROL, 8'h00);
    rdc(8'hAF, 8'h00, 1'b0);
    wr(ADDR_COUNT_LOW, 8'h34);
    rdc(ADDR_COUNT_LOW, 8'h34);
    rdc(ADDR_COUNT_HIGH, 8'hFF);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_pwm();
    wr(ADDR_RELOAD_LOW, 8'h03);
    wr(ADDR_RELOAD_HIGH, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h01);
    wr(ADDR_COUNT_HIGH, 8'h00);
    wr(ADDR_CONTROL, 8'h94);
    u_mdt_cpu_model.tick(2);
    rdc(ADDR_COUNT_LOW, 8'h03);
    rdc(ADDR_CONTROL, 8'h9C);
    chk("irq masked", 16'h0, {15'h0, timerIrq});
    u_mdt_cpu_model.gie(1'b1);
    waitOut();
    waitOut();
    chk("irq", 16'h1, {15'h0, timerIrq});
    wr(ADDR_CONTROL, 8'h84);
    u_mdt_cpu_model.tick(3);
    rdc(ADDR_COUNT_LOW, 8'h03);
    chk("irq cleared", 16'h0, {15'h0, timerIrq});
    wr(ADDR_CONTROL, 8'h90);
    u_mdt_cpu_model.tick(1);
    rdc(ADDR_COUNT_LOW, 8'h02);
    u_mdt_cpu_model.gie(1'b0);
    $display("test_pwm done");
  endtask : test_pwm

  task automatic test_toggle();
    wr(ADDR_RELOAD_LOW, 8'h01);
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'hB0);
    waitOut();
    chk("alt", 16'h1, {15'h0, timerPinAltActive});
    u_mdt_cpu_model.tick(1);
    waitOut();
    chk("pin", 16'h1, {15'h0, timerPinOut});
    u_mdt_cpu_model.tick(2);
    waitOut();
    chk("pin", 16'h0, {15'h0, timerPinOut});
    @(posedge sys_clk);
    portLineTwoOut <= 1'b1;
    waitOut();
    chk("pin port", 16'h1, {15'h0, timerPinOut});
    $display("test_toggle done");
  endtask : test_toggle

  task automatic test_event();
    wr(ADDR_COUNT_LOW, 8'h05);
    wr(ADDR_CONTROL, 8'h10);
    waitOut();
    chk("alt off", 16'h0, {15'h0, timerPinAltActive});
    chk("pin plain", 16'h1, {15'h0, timerPinOut});
    @(posedge sys_clk);
    portLineTwoOut <= 1'b0;
    waitOut();
    chk("pin plain", 16'h0, {15'h0, timerPinOut});
    pulse();
    pulse();
    u_mdt_cpu_model.tick(2);
    rdc(ADDR_COUNT_LOW, 8'h03);
    wr(ADDR_CONTROL, 8'h30);
    pulse();
    rdc(ADDR_COUNT_LOW, 8'h02);
    $display("test_event done");
  endtask : test_event

  task automatic test_capture();
    wr(ADDR_COUNT_LOW, 8'h10);
    wr(ADDR_CONTROL, 8'h44);
    u_mdt_cpu_model.tick(3);
    pulse();
    rdc(ADDR_RELOAD_LOW, 8'h0D);
    rdc(ADDR_CONTROL, 8'h4C);
    wr(ADDR_COUNT_LOW, 8'h00);
    u_mdt_cpu_model.tick(1);
    rdc(ADDR_COUNT_HIGH, 8'hFF);
    rdc(ADDR_CONTROL, 8'h5C);
    wr(ADDR_CONTROL, 8'h60);
    pulse();
    rdc(ADDR_RELOAD_LOW, 8'hFF);
    wr(ADDR_CONTROL, 8'hD0);
    u_mdt_cpu_model.tick(2);
    pulse();
    rdc(ADDR_COUNT_LOW, 8'hFF);
    rdc(ADDR_COUNT_HIGH, 8'hFF);
    $display("test_capture done");
  endtask : test_capture

  task automatic test_rerst();
    wr(ADDR_RELOAD_HIGH, 8'h12);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(ADDR_RELOAD_HIGH, 8'h00);
    rdc(ADDR_COUNT_LOW, 8'hFF);
    rdc(ADDR_CONTROL, 8'h00);
    $display("test_rerst done");
  endtask : test_rerst

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    errTotal++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    timerPinIn = 1'b0;
    portLineTwoOut = 1'b0;
    errTotal = 0;
    compares = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_pwm();
    test_toggle();
    test_event();
    test_capture();
    test_rerst();
    end_of_test();
  end
endmodule : tb
